// ===== rtl/hotswap_cfg_params.svh
// offsets, field positions, reset values and timing counts of the config bank
// Operation
// - unused upper bits ignore writes, read zero
// - four-bit startup delay, ten milliseconds per count
// - delay timer starts when stored-config copy ends
// - enable input checked only after delay expires
// - timeout-reset bit chooses bus machine reset
// - two-bit field selects timeout counting condition
// - source zero: upper bits plus strap nibble
// - source one: address wholly from register
// - upper three address bits always from register
// - strap mode reads back strap-derived nibble
// - signed four-bit offset added to voltage result
`ifndef HOTSWAP_CFG_PARAMS_SVH
`define HOTSWAP_CFG_PARAMS_SVH

`define OFS_STARTUP_DELAY 8'hd0
`define OFS_BUS_ADDRESS 8'hd2
`define OFS_VIN_TRIM 8'he3

// field positions inside the bus address register
`define POS_TO_RESET 10
`define POS_TO_COND 8
`define POS_ADDR_SRC 7
`define POS_ADDR_UPPER 4
`define POS_ADDR_LOW 0

// reset values of the stored fields
`define RST_STARTUP_DELAY 4'h0
`define RST_ADDR_CFG 11'h000
`define RST_VIN_TRIM 4'h0

// timing: figures in milliseconds, clock in MHz
`define CLK_MHZ 250
`define DELAY_STEP_MS 10
`define DELAY_STEP_CYCLES (`DELAY_STEP_MS * 1000 * `CLK_MHZ)
`define BUS_TIMEOUT_MS 25
`define BUS_TIMEOUT_CYCLES (`BUS_TIMEOUT_MS * 1000 * `CLK_MHZ)

`endif

// ===== rtl/hotswap_cfg_pkg.sv
// types shared by the configuration bank files
package hotswap_cfg_pkg;

	typedef enum logic [1:0] {
		TO_ALWAYS,
		TO_CLK_LOW,
		TO_DATA_LOW,
		TO_BOTH_LOW
	} timeout_cond_t;

	typedef struct packed {
		logic to_reset;
		timeout_cond_t to_cond;
		logic addr_src;
		logic [2:0] address_upper_bits;
		logic [3:0] address_low_nibble;
	} addr_cfg_t;

	// pin-side inputs, synchronised together, each bit accepted on its own
	typedef struct packed {
		logic scl;
		logic sda;
		logic en;
		logic [3:0] strap;
	} pins_t;

	typedef enum {
		DLY_IDLE,
		DLY_RUN,
		DLY_DONE
	} delay_state_t;

endpackage

// ===== rtl/startup_delay_timer.sv
// startup delay timer: counts ten-millisecond steps after config copy ends
`timescale 1ns/1ps
`default_nettype none
`include "hotswap_cfg_params.svh"

module startup_delay_timer import hotswap_cfg_pkg::*; #(
	parameter int unsigned STEP_CYCLES = `DELAY_STEP_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// control
	input wire logic start,
	input wire logic [3:0] steps,
	// status
	output logic expired_q
);

	delay_state_t state_q, state_d;
	logic [31:0] pre_q, pre_d;
	logic [3:0] left_q, left_d;
	logic expired_d;

	always_comb begin
		state_d = state_q;
		pre_d = pre_q;
		left_d = left_q;
		expired_d = expired_q;
		case (state_q)
			DLY_IDLE: begin
				if (start) begin
					pre_d = 32'h0;
					left_d = steps;
					// a zero setting expires at once
					if (steps == 4'h0) begin
						state_d = DLY_DONE;
						expired_d = 1'b1;
					end else begin
						state_d = DLY_RUN;
					end
				end
			end
			DLY_RUN: begin
				if (left_q == 4'h0) begin
					// restart with a zero setting: one cycle low, then done
					state_d = DLY_DONE;
					expired_d = 1'b1;
				end else if (pre_q == STEP_CYCLES - 1) begin
					pre_d = 32'h0;
					left_d = left_q - 4'h1;
					if (left_q == 4'h1) begin
						state_d = DLY_DONE;
						expired_d = 1'b1;
					end
				end else begin
					pre_d = pre_q + 32'h1;
				end
			end
			DLY_DONE: begin
				// a later copy restarts the wait from the current setting
				if (start) begin
					state_d = DLY_RUN;
					pre_d = 32'h0;
					left_d = steps;
					expired_d = 1'b0;
				end
			end
			default: begin
				state_d = DLY_IDLE;
				expired_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= DLY_IDLE;
			pre_q <= 32'h0;
			left_q <= 4'h0;
			expired_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pre_q <= pre_d;
			left_q <= left_d;
			expired_q <= expired_d;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/hotswap_cfg_regs.sv
// configuration bank: startup delay, bus address and timeout, voltage trim
`timescale 1ns/1ps
`default_nettype none
`include "hotswap_cfg_params.svh"

module hotswap_cfg_regs import hotswap_cfg_pkg::*; #(
	parameter int unsigned STEP_CYCLES = `DELAY_STEP_CYCLES,
	parameter int unsigned TIMEOUT_CYCLES = `BUS_TIMEOUT_CYCLES,
	parameter int unsigned ADC_W = 12
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// command port from the serial bus engine and the config copy engine
	input wire logic [7:0] cmd_code,
	input wire logic wr_stb,
	input wire logic [15:0] wr_data,
	input wire logic rd_stb,
	output logic [15:0] rd_data_q,
	output logic rd_valid_q,
	// config copy from non-volatile memory has finished (pulse)
	input wire logic copy_done,
	// pins from outside the clock domain
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic en_in,
	input wire logic [3:0] addr_strap,
	// address compare and timeout
	input wire logic bus_busy,
	input wire logic rx_addr_valid,
	input wire logic [6:0] rx_addr,
	output logic [6:0] bus_address_q,
	output logic addr_match_q,
	output logic timeout_q,
	output logic bus_sm_reset_q,
	// startup
	output logic delay_done_q,
	output logic en_active_q,
	// input-voltage sense path
	input wire logic vin_valid,
	input wire logic [ADC_W-1:0] vin_raw,
	output logic vin_corr_valid_q,
	output logic [ADC_W-1:0] vin_corr_q
);

	localparam logic [ADC_W+1:0] VMAX = {2'b00, {ADC_W{1'b1}}};

	function automatic logic [ADC_W-1:0] trim_add(
		input logic [ADC_W-1:0] raw,
		input logic [3:0] ofs
	);
		logic signed [ADC_W+1:0] sum;
		sum = $signed({2'b00, raw}) + $signed({{(ADC_W-2){ofs[3]}}, ofs});
		// clamp rather than wrap: a small negative trim on zero stays zero
		if (sum < 0) begin
			trim_add = '0;
		end else if (sum > $signed(VMAX)) begin
			trim_add = {ADC_W{1'b1}};
		end else begin
			trim_add = sum[ADC_W-1:0];
		end
	endfunction

	// one-hot register select, shared by the write and read paths
	function automatic logic [2:0] reg_sel(input logic [7:0] code);
		case (code)
			`OFS_STARTUP_DELAY: reg_sel = 3'b001;
			`OFS_BUS_ADDRESS: reg_sel = 3'b010;
			`OFS_VIN_TRIM: reg_sel = 3'b100;
			default: reg_sel = 3'b000;
		endcase
	endfunction

	// address register fields from a written word; bits 15:11 dropped
	function automatic addr_cfg_t addr_fields(input logic [15:0] w);
		addr_cfg_t c;
		c.to_reset = w[`POS_TO_RESET];
		c.to_cond = timeout_cond_t'(w[`POS_TO_COND+:2]);
		c.addr_src = w[`POS_ADDR_SRC];
		c.address_upper_bits = w[`POS_ADDR_UPPER+:3];
		c.address_low_nibble = w[`POS_ADDR_LOW+:4];
		addr_fields = c;
	endfunction

	// address register read word; unused bits read zero
	function automatic logic [15:0] addr_word(
		input addr_cfg_t c,
		input logic [3:0] low
	);
		logic [15:0] w;
		w = 16'h0000;
		w[`POS_TO_RESET] = c.to_reset;
		w[`POS_TO_COND+:2] = c.to_cond;
		w[`POS_ADDR_SRC] = c.addr_src;
		w[`POS_ADDR_UPPER+:3] = c.address_upper_bits;
		w[`POS_ADDR_LOW+:4] = low;
		addr_word = w;
	endfunction

	// pin synchronisers: a change counts once stages two and three agree
	pins_t s1_q, s2_q, s3_q, pin_q, pin_d;

	always_comb begin
		pin_d = pin_q;
		for (int i = 0; i < $bits(pins_t); i++) begin
			if (s2_q[i] == s3_q[i]) begin
				pin_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			// idle levels: lines released, strap f, enable high
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			pin_q <= '1;
		end else begin
			s1_q <= {scl_in, sda_in, en_in, addr_strap};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	// registers: only the defined fields are stored
	logic [3:0] delay_q, delay_d;
	addr_cfg_t acfg_q, acfg_d;
	logic [3:0] trim_q, trim_d;
	logic [15:0] rd_data_d;
	logic rd_valid_d;
	logic [3:0] low_eff;
	logic [2:0] sel;

	assign sel = reg_sel(cmd_code);

	assign low_eff = acfg_q.addr_src ? acfg_q.address_low_nibble
		: pin_q.strap;

	always_comb begin
		delay_d = delay_q;
		acfg_d = acfg_q;
		trim_d = trim_q;
		if (wr_stb && sel[0]) begin
			delay_d = wr_data[3:0];
		end
		if (wr_stb && sel[1]) begin
			acfg_d = addr_fields(wr_data);
		end
		if (wr_stb && sel[2]) begin
			trim_d = wr_data[3:0];
		end
	end

	always_comb begin
		rd_data_d = rd_data_q;
		rd_valid_d = rd_stb;
		if (rd_stb) begin
			// unmapped codes and unused bits read as zero
			rd_data_d = 16'h0000;
			if (sel[0]) begin
				rd_data_d[3:0] = delay_q;
			end
			if (sel[1]) begin
				rd_data_d = addr_word(acfg_q, low_eff);
			end
			if (sel[2]) begin
				rd_data_d[3:0] = trim_q;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			delay_q <= `RST_STARTUP_DELAY;
			acfg_q <= `RST_ADDR_CFG;
			trim_q <= `RST_VIN_TRIM;
			rd_data_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end else begin
			delay_q <= delay_d;
			acfg_q <= acfg_d;
			trim_q <= trim_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	// bus address and match
	logic [6:0] bus_address_d;
	logic addr_match_d;

	always_comb begin
		bus_address_d = {acfg_q.address_upper_bits, low_eff};
		addr_match_d = rx_addr_valid && (rx_addr == bus_address_q);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			bus_address_q <= 7'h00;
			addr_match_q <= 1'b0;
		end else begin
			bus_address_q <= bus_address_d;
			addr_match_q <= addr_match_d;
		end
	end

	// bus timeout: counts only while a transfer is open and the chosen
	// line condition holds; a break in the condition restarts it
	// the lines pass the synchroniser, so the condition lags a few cycles
	logic [31:0] to_cnt_q, to_cnt_d;
	logic timeout_d, bus_sm_reset_d;
	logic cond_ok;

	always_comb begin
		case (acfg_q.to_cond)
			TO_ALWAYS: cond_ok = 1'b1;
			TO_CLK_LOW: cond_ok = !pin_q.scl;
			TO_DATA_LOW: cond_ok = !pin_q.sda;
			TO_BOTH_LOW: cond_ok = !pin_q.scl && !pin_q.sda;
			default: cond_ok = 1'b0;
		endcase
	end

	always_comb begin
		to_cnt_d = to_cnt_q;
		timeout_d = 1'b0;
		bus_sm_reset_d = 1'b0;
		if (!bus_busy || !cond_ok) begin
			to_cnt_d = 32'h0;
		end else if (to_cnt_q == TIMEOUT_CYCLES - 1) begin
			to_cnt_d = 32'h0;
			timeout_d = 1'b1;
			bus_sm_reset_d = acfg_q.to_reset;
		end else begin
			to_cnt_d = to_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			to_cnt_q <= 32'h0;
			timeout_q <= 1'b0;
			bus_sm_reset_q <= 1'b0;
		end else begin
			to_cnt_q <= to_cnt_d;
			timeout_q <= timeout_d;
			bus_sm_reset_q <= bus_sm_reset_d;
		end
	end

	// startup delay and enable gating
	logic expired;
	logic delay_done_d, en_active_d;

	startup_delay_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_delay (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(copy_done),
		.steps(delay_q),
		.expired_q(expired)
	);

	always_comb begin
		delay_done_d = expired;
		// enable is not looked at before the delay has run out
		en_active_d = expired && pin_q.en;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			delay_done_q <= 1'b0;
			en_active_q <= 1'b0;
		end else begin
			delay_done_q <= delay_done_d;
			en_active_q <= en_active_d;
		end
	end

	// voltage sense trim, one cycle through
	logic [ADC_W-1:0] vin_corr_d;
	logic vin_corr_valid_d;

	always_comb begin
		vin_corr_valid_d = vin_valid;
		vin_corr_d = vin_corr_q;
		if (vin_valid) begin
			vin_corr_d = trim_add(vin_raw, trim_q);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			vin_corr_q <= '0;
			vin_corr_valid_q <= 1'b0;
		end else begin
			vin_corr_q <= vin_corr_d;
			vin_corr_valid_q <= vin_corr_valid_d;
		end
	end

endmodule
`default_nettype wire

// ===== tb/hotswap_cfg_regs_sva.sv
// port assertions for the config bank
`timescale 1ns/1ps
`default_nettype none
module hotswap_cfg_regs_sva (
	// clock, reset, command port
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] cmd_code,
	input wire logic wr_stb,
	input wire logic [15:0] wr_data,
	input wire logic rd_stb,
	input wire logic [15:0] rd_data_q,
	input wire logic rd_valid_q,
	// status and side paths
	input wire logic copy_done,
	input wire logic bus_busy,
	input wire logic rx_addr_valid,
	input wire logic [6:0] rx_addr,
	input wire logic [6:0] bus_address_q,
	input wire logic addr_match_q,
	input wire logic timeout_q,
	input wire logic bus_sm_reset_q,
	input wire logic delay_done_q,
	input wire logic en_active_q,
	input wire logic vin_valid,
	input wire logic vin_corr_valid_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_rd; rd_stb |=> rd_valid_q; endproperty
	a_rd: assert property (p_rd) else $error("read late");
	property p_zero;
		rd_valid_q && $past(cmd_code) != 8'hd2 |-> rd_data_q[15:4] == 12'h000;
	endproperty
	a_zero: assert property (p_zero) else $error("upper not 0");
	property p_upper;
		wr_stb && cmd_code == 8'hd2 |-> ##2
			bus_address_q[6:4] == $past(wr_data[6:4], 2);
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits");
	property p_low;
		wr_stb && cmd_code == 8'hd2 && wr_data[7] |-> ##2
			bus_address_q[3:0] == $past(wr_data[3:0], 2);
	endproperty
	a_low: assert property (p_low) else $error("low nibble");
	property p_match;
		rx_addr_valid |=> addr_match_q == ($past(rx_addr) == $past(bus_address_q));
	endproperty
	a_match: assert property (p_match) else $error("match");
	property p_smr; bus_sm_reset_q |-> timeout_q; endproperty
	a_smr: assert property (p_smr) else $error("sm reset alone");
	property p_busy; timeout_q |-> $past(bus_busy); endproperty
	a_busy: assert property (p_busy) else $error("idle timeout");
	property p_vin; vin_valid |=> vin_corr_valid_q; endproperty
	a_vin: assert property (p_vin) else $error("trim late");
	property p_en; en_active_q |-> delay_done_q; endproperty
	a_en: assert property (p_en) else $error("enable early");
	property p_copy; copy_done && delay_done_q |-> ##2 !delay_done_q; endproperty
	a_copy: assert property (p_copy) else $error("no restart");
endmodule
`default_nettype wire

// ===== tb/bus_host_model.sv
// host side: bus pins and busy level while a transfer stalls
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
	// stall request: bit0 holds clock low, bit1 data low
	input wire logic busy_req,
	input wire logic [1:0] hold_low,
	// bus side
	output logic scl_in,
	output logic sda_in,
	output logic bus_busy
);
	// released lines return high through the pull-ups
	assign scl_in = !(busy_req && hold_low[0]);
	assign sda_in = !(busy_req && hold_low[1]);
	assign bus_busy = busy_req;
endmodule
`default_nettype wire

// ===== tb/hotswap_cfg_regs_tb.sv
// bench for the config bank: register model, address, timeout, delay, trim
`timescale 1ns/1ps
`default_nettype none
module hotswap_cfg_regs_tb import hotswap_cfg_pkg::*;;
	localparam int STEP = 10;
	localparam int TMO = 20;
	logic mclk, rst_b, wr_stb, rd_stb, copy_done, en_in, rx_addr_valid;
	logic vin_valid, busy_req, rd_valid_q, scl_in, sda_in, bus_busy;
	logic addr_match_q, timeout_q, bus_sm_reset_q, delay_done_q;
	logic en_active_q, vin_corr_valid_q;
	logic [7:0] cmd_code;
	logic [15:0] wr_data, rd_data_q;
	logic [1:0] hold_low;
	logic [3:0] addr_strap;
	logic [6:0] rx_addr, bus_address_q;
	logic [11:0] vin_raw, vin_corr_q;
	logic [7:0] codes[4] = '{8'hd0, 8'hd2, 8'he3, 8'h55};
	int num_errors, check_count, seed, e, i, j, k;
	int mdl[3];

	hotswap_cfg_regs #(.STEP_CYCLES(STEP), .TIMEOUT_CYCLES(TMO), .ADC_W(12))
		i_hotswap_cfg_regs (.*);
	bus_host_model i_bus_host_model (.busy_req(busy_req),
		.hold_low(hold_low), .scl_in(scl_in), .sda_in(sda_in),
		.bus_busy(bus_busy));

	function automatic int model_rd(input logic [7:0] c);
		case (c)
			8'hd0: return mdl[0];
			8'hd2: return mdl[1][7] ? mdl[1] : (mdl[1] & 'h7f0) | addr_strap;
			8'he3: return mdl[2];
			default: return 0;
		endcase
	endfunction

	task automatic check(input string n, input int x, input logic [15:0] s);
		check_count++;
		if (s !== x[15:0]) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, x[15:0], s);
		end
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		cmd_code <= c;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
		@(posedge mclk);
		if (c == 8'hd0) mdl[0] = 32'(d[3:0]);
		if (c == 8'hd2) mdl[1] = 32'(d[10:0]);
		if (c == 8'he3) mdl[2] = 32'(d[3:0]);
	endtask

	task automatic rd(input logic [7:0] c);
		cmd_code <= c;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		check("rd_data_q", model_rd(c), rd_data_q);
		@(posedge mclk);
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// whole run needs a few hundred cycles
	initial begin
		#80000;
		num_errors++;
		conclude();
	end

	initial begin
		seed = 71;
		mdl = '{0, 0, 0};
		rst_b = 1'b0;
		en_in = 1'b1;
		addr_strap = 4'ha;
		{wr_stb, rd_stb, copy_done, rx_addr_valid, vin_valid, busy_req} = '0;
		{cmd_code, wr_data, hold_low, rx_addr, vin_raw} = '0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (6) @(posedge mclk);
		for (i = 0; i < 16; i++) begin
			wr(codes[i % 4], 16'($random(seed)));
			rd(codes[(i + 1) % 4]);
			rd(codes[i % 4]);
			e = model_rd(8'hd2) & 'h7f;
			check("bus_address_q", e, {9'h0, bus_address_q});
		end
		wr(8'hd2, 16'h0030);
		addr_strap <= 4'h5;
		repeat (6) @(posedge mclk);
		rd(8'hd2);
		check("bus_address_q", 'h35, {9'h0, bus_address_q});
		for (i = 0; i < 2; i++) begin
			rx_addr <= 7'(model_rd(8'hd2)) ^ 7'(i);
			rx_addr_valid <= 1'b1;
			@(posedge mclk);
			rx_addr_valid <= 1'b0;
			@(negedge mclk);
			check("addr_match_q", i == 0, {15'h0, addr_match_q});
			@(posedge mclk);
		end
		for (i = 0; i < 9; i++) begin
			wr(8'he3, 16'($random(seed)));
			k = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 'hfff : $random(seed) & 'hfff;
			vin_raw <= 12'(k);
			vin_valid <= 1'b1;
			@(posedge mclk);
			vin_valid <= 1'b0;
			@(negedge mclk);
			e = k + (mdl[2] > 7 ? mdl[2] - 16 : mdl[2]);
			e = e < 0 ? 0 : e > 4095 ? 4095 : e;
			check("vin_corr_q", e, {4'h0, vin_corr_q});
			@(posedge mclk);
		end
		wr(8'hd0, 16'hfff3);
		rd(8'hd0);
		copy_done <= 1'b1;
		@(posedge mclk);
		copy_done <= 1'b0;
		repeat (3 * STEP) @(posedge mclk);
		@(negedge mclk);
		check("delay_done_q", 0, {15'h0, delay_done_q});
		check("en_active_q", 0, {15'h0, en_active_q});
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check("delay_done_q", 1, {15'h0, delay_done_q});
		repeat (3) @(posedge mclk);
		check("en_active_q", 1, {15'h0, en_active_q});
		copy_done <= 1'b1;
		@(posedge mclk);
		copy_done <= 1'b0;
		repeat (3) @(posedge mclk);
		check("delay_done_q", 0, {15'h0, delay_done_q});
		repeat (27) @(posedge mclk);
		@(negedge mclk);
		check("delay_done_q", 0, {15'h0, delay_done_q});
		@(posedge mclk);
		en_in <= 1'b0;
		@(negedge mclk);
		check("delay_done_q", 1, {15'h0, delay_done_q});
		repeat (6) @(posedge mclk);
		check("en_active_q", 0, {15'h0, en_active_q});
		for (i = 0; i < 8; i++) begin
			k = ($random(seed) & 'h400) | ((i / 2) << 8);
			wr(8'hd2, 16'(k | 'h80));
			hold_low <= (i % 2 == 1) ? 2'(i / 2) : 2'b00;
			busy_req <= 1'b1;
			j = 0;
			e = 0;
			repeat (TMO + 15) begin
				@(negedge mclk);
				j += timeout_q;
				e += bus_sm_reset_q;
			end
			@(posedge mclk);
			busy_req <= 1'b0;
			check("timeout_q", i % 2 == 1 || i < 2, 16'(j));
			check("bus_sm_reset_q", (i % 2 == 1 || i < 2) && k[10], 16'(e));
			repeat (6) @(posedge mclk);
		end
		conclude();
	end
endmodule

bind hotswap_cfg_regs hotswap_cfg_regs_sva i_hotswap_cfg_regs_sva (.*);
`default_nettype wire
